// file: tb/fieldbus_master_model.sv
/*
  behavioural fieldbus master: drives exchange strobes with output data,
  local interface accesses and the channel setup flags.
  assumes its tasks are called right after a rising edge of clk.
*/
module fieldbus_master_model (
  input  wire logic       clk,     // reference clock
  output logic            xchg,    // exchange done strobe
  output logic [7:0]      pd,      // master output data
  output logic            pdi,     // local interface access
  output logic            mbx_ok,  // mailbox setup valid
  output logic            pd_ok    // process setup valid
);
  timeunit 1ns;
  timeprecision 1ps;

  // idle levels at time zero
  initial begin
    xchg = 1'b0;
    pd = 8'hFF;
    pdi = 1'b0;
    mbx_ok = 1'b0;
    pd_ok = 1'b0;
  end

  // mailbox channels first, process channels later
  task automatic setup(input logic m, input logic p);
    mbx_ok <= m;
    pd_ok <= p;
    @(posedge clk);
  endtask

  // data stable around the strobe, then inverted so stale data is not read
  task automatic exchange(input logic [7:0] d);
    pd <= d;
    @(posedge clk);
    xchg <= 1'b1;
    repeat (4) @(posedge clk);
    xchg <= 1'b0;
    pd <= ~d;
    repeat (3) @(posedge clk);
  endtask

  // strobe low at least three clocks between edges
  task automatic local_access();
    pdi <= 1'b1;
    repeat (2) @(posedge clk);
    pdi <= 1'b0;
    repeat (3) @(posedge clk);
  endtask
endmodule

// file: tb/output_watchdog_state_control_test.sv
/*
  self-checking bench: apb register tasks and state and watchdog scenarios.
  assumes the design package and a multiplier of 1 (15 clock tick) in tests.
*/
module output_watchdog_state_control_test;
  timeunit 1ns;
  timeprecision 1ps;
  import wdog_state_pkg::*;

  logic             clk = 1'b0, rst, psel, pen, pwr;
  logic [11:0]      paddr;
  logic [31:0]      pwdata, prdata, rv;
  logic             pready, pslverr, ev, xchg, pdi, mbx_ok, pd_ok;
  logic             mbx_al, file_access_mailbox, pd_al, load, sm_trip, pdi_trip;
  logic [OUT_W-1:0] pd, outs;
  int               err_total = 0, check_count = 0, loads = 0;

  // 125 MHz clock
  always #4 clk = ~clk;

  // count input load pulses
  always @(posedge clk) if (load === 1'b1) loads++;

  output_watchdog_state_control output_watchdog_state_control_i (.I_REF_CLK(clk), .I_RESET(rst),
    .I_PSEL(psel), .I_PENABLE(pen), .I_PWRITE(pwr), .I_PADDR(paddr), .I_PWDATA(pwdata),
    .O_PRDATA(prdata), .O_PREADY(pready), .O_PSLVERR(pslverr), .I_PD_XCHG(xchg), .I_PD_OUT(pd),
    .I_PDI_ACCESS(pdi), .I_MBX_CFG_OK(mbx_ok), .I_PD_CFG_OK(pd_ok), .O_OUTPUTS(outs),
    .O_MBX_ALLOWED(mbx_al), .O_FOE_ONLY(file_access_mailbox), .O_PD_ALLOWED(pd_al), .O_INPUT_LOAD(load),
    .O_SM_TRIP(sm_trip), .O_PDI_TRIP(pdi_trip));

  fieldbus_master_model fieldbus_master_model_i (.clk(clk), .xchg(xchg), .pd(pd), .pdi(pdi),
    .mbx_ok(mbx_ok), .pd_ok(pd_ok));

  task automatic report_and_stop();
    $display("errors %0d checks %0d", err_total, check_count);
    if (err_total == 0 && check_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  // one apb transfer; the extra idle edge keeps strobes from being driven twice
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1; pen <= 1'b0; pwr <= w; paddr <= a; pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    do begin @(posedge clk); n++; end while (pready !== 1'b1 && n < 20);
    rv = prdata;
    ev = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
    @(posedge clk);
    if (n >= 20) chk(32'h0, 32'h1, "no ready");
  endtask

  task automatic rdm(input logic [11:0] a, input logic [31:0] mk, input logic [31:0] x, input string m);
    apb(1'b0, a, 32'h0);
    chk(rv & mk, x, m);
  endtask

  function automatic logic [31:0] sx(input logic rf, input slave_state_e s);
    return {21'h0, rf, 4'h0, s};
  endfunction

  task automatic req(input logic [2:0] c, input logic [31:0] x);
    apb(1'b1, OFS_REQ, {29'h0, c});
    rdm(OFS_STATUS, 32'h0000043F, x, "state");
  endtask

  // bounded wait for a trip flag
  task automatic wait_trip(input bit loc, input int lim);
    int n;
    n = 0;
    while ((loc ? pdi_trip : sm_trip) !== 1'b1 && n < lim) begin @(posedge clk); n++; end
    chk(32'(n < lim), 32'h1, "trip missing");
  endtask

  // main sequence; bus idle and reset asserted from time zero
  initial begin
    rst = 1'b1;
    psel = 1'b0;
    pen = 1'b0;
    pwr = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rdm(OFS_CTRL, 32'h3, 32'h3, "ctrl reset");
    rdm(OFS_MULT, 32'hFFFF, 32'h09C2, "mult reset");
    rdm(OFS_SM_TMR, 32'hFFFF, 32'h03E8, "sync timer reset");
    rdm(OFS_PDI_TMR, 32'hFFFF, 32'h03E8, "local timer reset");
    rdm(OFS_STATUS, 32'h0000043F, sx(1'b0, ST_INIT), "power-on state");
    chk(32'({mbx_al, pd_al, outs}), 32'h0, "init gates");
    apb(1'b0, 12'h020, 32'h0);
    chk(32'(ev), 32'h1, "unmapped");
    req(REQ_SAFEOP, sx(1'b1, ST_INIT));
    req(REQ_BOOT, sx(1'b0, ST_BOOT));
    chk(32'({file_access_mailbox, pd_al}), 32'h2, "boot file access only");
    req(REQ_PREOP, sx(1'b1, ST_BOOT));
    req(REQ_INIT, sx(1'b0, ST_INIT));
    // start-up settings: short tick and short timers
    apb(1'b1, OFS_MULT, 32'h1);
    apb(1'b1, OFS_MULT, 32'h0);
    rdm(OFS_MULT, 32'hFFFF, 32'h1, "mult zero kept");
    apb(1'b1, OFS_SM_TMR, 32'hFFFF);
    rdm(OFS_SM_TMR, 32'hFFFF, 32'hFFFF, "timer max");
    apb(1'b1, OFS_SM_TMR, 32'h4);
    apb(1'b1, OFS_PDI_TMR, 32'h4);
    req(REQ_PREOP, sx(1'b1, ST_INIT));
    fieldbus_master_model_i.setup(1'b1, 1'b0);
    req(REQ_PREOP, sx(1'b0, ST_PREOP));
    chk(32'({mbx_al, pd_al}), 32'h2, "preop mailbox only");
    req(REQ_BOOT, sx(1'b1, ST_PREOP));
    req(REQ_SAFEOP, sx(1'b1, ST_PREOP));
    fieldbus_master_model_i.setup(1'b1, 1'b1);
    req(REQ_SAFEOP, sx(1'b0, ST_SAFEOP));
    chk(32'(loads), 32'h1, "input load");
    fieldbus_master_model_i.exchange(8'hA5);
    chk(32'({pd_al, outs}), 32'h100, "safeop outputs safe");
    req(REQ_OP, sx(1'b0, ST_OP));
    chk(32'(outs), 32'hA5, "op copies data");
    fieldbus_master_model_i.exchange(8'h5A);
    chk(32'({sm_trip, outs}), 32'h05A, "new data");
    repeat (35) @(posedge clk);
    chk(32'(sm_trip), 32'h0, "early trip");
    wait_trip(1'b0, 80);
    repeat (2) @(posedge clk);
    chk(32'(outs), 32'h0, "outputs forced off");
    rdm(OFS_STATUS, 32'h0000013F, 32'h00000108, "op kept on trip");
    fieldbus_master_model_i.exchange(8'h3C);
    chk(32'({sm_trip, outs}), 32'h03C, "restart clears trip");
    // local interface kept alive, then left silent
    repeat (6) begin fieldbus_master_model_i.local_access(); repeat (25) @(posedge clk); end
    chk(32'(pdi_trip), 32'h0, "local kept alive");
    wait_trip(1'b1, 120);
    apb(1'b1, OFS_SM_TMR, 32'h0);
    fieldbus_master_model_i.exchange(8'h81);
    repeat (150) @(posedge clk);
    chk(32'({sm_trip, outs}), 32'h081, "zero timer disables");
    req(REQ_SAFEOP, sx(1'b0, ST_SAFEOP));
    fieldbus_master_model_i.exchange(8'h42);
    chk(32'(outs), 32'h42, "safeop switch, timer zero");
    apb(1'b1, OFS_SM_TMR, 32'h4);
    apb(1'b1, OFS_CTRL, 32'h2);
    fieldbus_master_model_i.exchange(8'h24);
    repeat (150) @(posedge clk);
    chk(32'({sm_trip, outs}), 32'h024, "safeop switch, disabled");
    report_and_stop();
  end

  // hang guard, well beyond the expected run length
  initial begin
    #60us;
    err_total++;
    $display("CHECK FAILED %0t timeout", $time);
    report_and_stop();
  end
endmodule

// file: verilog/output_watchdog_state_control.sv
/*
  output watchdog and slave state machine: two communication watchdogs on a
  shared tick prescaler, of which only the sync one gates the physical outputs,
  and the state machine decides when master output data may reach them.
  assumes an APB master on I_REF_CLK and asynchronous strobes and data from
  the fieldbus side and the local process-data interface.
*/
// Operation
// - restart sync watchdog only on good exchange
// - sync watchdog timeout forces outputs false
// - sync watchdog trip leaves state unchanged
// - local interface silence trips its watchdog
// - both watchdogs default to 100 ms
// - one multiplier, separate timer per watchdog
// - tick lasts multiplier plus two base periods
// - multiplier resets to 2498, 100 us
// - sync timer resets to 1000 ticks
// - timer 0..65535, multiplier 1..65535
// - timer zero disables sync watchdog entirely
// - power-on enters Init, no communication
// - check mailbox setup; preop mailbox only
// - check channels, load inputs, then acknowledge
// - safeop allows all, outputs held safe
// - watchdog off lets safeop switch outputs
// - op copies master outputs to pins
// - boot only from Init, file access only
module output_watchdog_state_control
  import wdog_state_pkg::*;
(
  input  wire logic                       I_REF_CLK,       // 125 MHz clock
  input  wire logic                       I_RESET,         // async reset, high
  input  wire logic                       I_PSEL,          // apb select
  input  wire logic                       I_PENABLE,       // apb access phase
  input  wire logic                       I_PWRITE,        // apb direction
  input  wire logic [11:0]                I_PADDR,         // apb byte address
  input  wire logic [31:0]                I_PWDATA,        // apb write data
  output logic      [31:0]                O_PRDATA,        // apb read data
  output logic                            O_PREADY,        // apb ready
  output logic                            O_PSLVERR,       // apb error
  input  wire logic                       I_PD_XCHG,       // process data exchange done, async
  input  wire logic [wdog_state_pkg::OUT_W-1:0] I_PD_OUT, // master output data, async
  input  wire logic                       I_PDI_ACCESS,    // local interface access, async
  input  wire logic                       I_MBX_CFG_OK,    // mailbox channels valid, async
  input  wire logic                       I_PD_CFG_OK,     // process channels valid, async
  output logic [wdog_state_pkg::OUT_W-1:0] O_OUTPUTS,      // physical outputs
  output logic                            O_MBX_ALLOWED,   // mailbox traffic allowed
  output logic                            O_FOE_ONLY,      // only file access mailbox
  output logic                            O_PD_ALLOWED,    // process data allowed
  output logic                            O_INPUT_LOAD,    // load inputs to shared memory
  output logic                            O_SM_TRIP,       // sync watchdog tripped
  output logic                            O_PDI_TRIP       // local watchdog tripped
);
  import wdog_state_pkg::*;

  // synchronisers: first stage read only by the second
  logic [OUT_W+3:0] sy1_q, sy2_q;
  logic             xchg_d3_q, pdi_d3_q;
  logic [OUT_W+3:0] sy_in;
  assign sy_in = {I_PD_OUT, I_PD_CFG_OK, I_MBX_CFG_OK, I_PDI_ACCESS, I_PD_XCHG};

  always_ff @(posedge I_REF_CLK or posedge I_RESET) begin
    if (I_RESET) begin
      sy1_q     <= '0;
      sy2_q     <= '0;
      xchg_d3_q <= 1'b0;
      pdi_d3_q  <= 1'b0;
    end else begin
      sy1_q     <= sy_in;
      sy2_q     <= sy1_q;
      xchg_d3_q <= sy2_q[0];
      pdi_d3_q  <= sy2_q[1];
    end
  end

  wire              xchg_pulse = sy2_q[0] & ~xchg_d3_q;
  wire              pdi_pulse  = sy2_q[1] & ~pdi_d3_q;
  wire              mbx_cfg_ok = sy2_q[2];
  wire              pd_cfg_ok  = sy2_q[3];
  wire [OUT_W-1:0]  pd_data    = sy2_q[OUT_W+3:4];

  // register state
  logic [1:0]   ctrl_q;
  logic [15:0]  mult_q, sm_tmr_q, pdi_tmr_q;
  logic         refused_q;
  slave_state_e st_q, st_d;

  // apb decode
  wire setup    = I_PSEL & ~I_PENABLE;
  wire wr_acc   = I_PSEL & I_PENABLE & O_PREADY & I_PWRITE;
  wire hit_ctrl = I_PADDR == OFS_CTRL;
  wire hit_req  = I_PADDR == OFS_REQ;
  wire hit_stat = I_PADDR == OFS_STATUS;
  wire hit_mult = I_PADDR == OFS_MULT;
  wire hit_smt  = I_PADDR == OFS_SM_TMR;
  wire hit_pdt  = I_PADDR == OFS_PDI_TMR;
  wire mapped   = hit_ctrl | hit_req | hit_stat | hit_mult | hit_smt | hit_pdt;
  wire req_wr   = wr_acc & hit_req;
  wire [2:0] req_code = I_PWDATA[2:0];
  wire [15:0] wr_half = I_PWDATA[15:0];

  wire [31:0] rd_val =
      hit_ctrl ? {30'h0, ctrl_q} :
      hit_req  ? 32'h0 :
      hit_stat ? {21'h0, refused_q, O_PDI_TRIP, O_SM_TRIP, 2'h0, st_q} :
      hit_mult ? {16'h0, mult_q} :
      hit_smt  ? {16'h0, sm_tmr_q} :
      hit_pdt  ? {16'h0, pdi_tmr_q} : 32'h0;

  // answer one cycle after setup, so every access has one access cycle
  always_ff @(posedge I_REF_CLK or posedge I_RESET) begin
    if (I_RESET) begin
      O_PREADY  <= 1'b0;
      O_PSLVERR <= 1'b0;
      O_PRDATA  <= 32'h0;
    end else begin
      O_PREADY  <= setup;
      O_PSLVERR <= setup & ~mapped;
      O_PRDATA  <= (setup & ~I_PWRITE) ? rd_val : 32'h0;
    end
  end

  // settings; a multiplier of zero is outside its range and is ignored
  always_ff @(posedge I_REF_CLK or posedge I_RESET) begin
    if (I_RESET) begin
      ctrl_q    <= CTRL_RST;
      mult_q    <= MULT_RST;
      sm_tmr_q  <= SM_TMR_RST;
      pdi_tmr_q <= PDI_TMR_RST;
    end else begin
      if (wr_acc & hit_ctrl) ctrl_q <= I_PWDATA[1:0];
      if (wr_acc & hit_mult & (wr_half != 16'h0)) mult_q <= wr_half;
      if (wr_acc & hit_smt) sm_tmr_q <= wr_half;
      if (wr_acc & hit_pdt) pdi_tmr_q <= wr_half;
    end
  end

  // shared prescaler: 5 clocks per 40 ns base period, mult + 2 per tick
  logic [2:0]  base_cnt_q;
  logic [16:0] tick_cnt_q;
  wire         base_en  = base_cnt_q == BASE_LAST;
  wire [16:0]  tick_end = {1'b0, mult_q} + TICK_EXTRA;
  wire         tick     = base_en & (tick_cnt_q == tick_end);

  always_ff @(posedge I_REF_CLK or posedge I_RESET) begin
    if (I_RESET) begin
      base_cnt_q <= 3'h0;
      tick_cnt_q <= 17'h0;
    end else begin
      base_cnt_q <= base_en ? 3'h0 : base_cnt_q + 3'h1;
      if (base_en) tick_cnt_q <= (tick_cnt_q >= tick_end) ? 17'h0 : tick_cnt_q + 17'h1;
    end
  end

  // state-dependent permissions
  wire pd_ok  = (st_q == ST_SAFEOP) | (st_q == ST_OP);
  wire mbx_ok = pd_ok | (st_q == ST_PREOP) | (st_q == ST_BOOT);

  // watchdogs: index 0 sync manager side, index 1 local interface side
  logic [15:0] wd_cnt_q [2];
  logic [1:0]  wd_trip_q;
  wire  [15:0] wd_tmr [2];
  wire  [1:0]  wd_active, wd_restart;
  assign wd_tmr[0]     = sm_tmr_q;
  assign wd_tmr[1]     = pdi_tmr_q;
  assign wd_active[0]  = ctrl_q[CTRL_SM_EN] & (sm_tmr_q != 16'h0);
  assign wd_active[1]  = ctrl_q[CTRL_PDI_EN] & (pdi_tmr_q != 16'h0);
  assign wd_restart[0] = xchg_pulse & pd_ok;
  assign wd_restart[1] = pdi_pulse;

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_wd
      wire expired = wd_active[gi] & (wd_cnt_q[gi] >= wd_tmr[gi]);
      always_ff @(posedge I_REF_CLK or posedge I_RESET) begin
        if (I_RESET) begin
          wd_cnt_q[gi]  <= 16'h0;
          wd_trip_q[gi] <= 1'b0;
        end else begin
          if (wd_restart[gi]) wd_cnt_q[gi] <= 16'h0;
          else if (tick & (wd_cnt_q[gi] != 16'hFFFF)) wd_cnt_q[gi] <= wd_cnt_q[gi] + 16'h1;
          if (wd_restart[gi] | ~wd_active[gi]) wd_trip_q[gi] <= 1'b0;
          else if (expired) wd_trip_q[gi] <= 1'b1;
        end
      end
    end
  endgenerate

  // state transitions; refused requests keep the state and flag it
  logic refuse;
  always_comb begin
    st_d   = st_q;
    refuse = 1'b0;
    unique case (st_q)
      ST_INIT: begin
        if (req_wr & (req_code == REQ_PREOP)) begin
          if (mbx_cfg_ok) st_d = ST_PREOP;
          else refuse = 1'b1;
        end else if (req_wr & (req_code == REQ_BOOT)) st_d = ST_BOOT;
        else if (req_wr & (req_code != REQ_INIT)) refuse = 1'b1;
      end
      ST_PREOP: begin
        if (req_wr & (req_code == REQ_SAFEOP)) begin
          if (pd_cfg_ok) st_d = ST_LOAD;
          else refuse = 1'b1;
        end else if (req_wr & (req_code == REQ_INIT)) st_d = ST_INIT;
        else if (req_wr & (req_code != REQ_PREOP)) refuse = 1'b1;
      end
      ST_LOAD: st_d = ST_SAFEOP;
      ST_SAFEOP: begin
        if (req_wr & (req_code == REQ_OP)) st_d = ST_OP;
        else if (req_wr & (req_code == REQ_PREOP)) st_d = ST_PREOP;
        else if (req_wr & (req_code == REQ_INIT)) st_d = ST_INIT;
        else if (req_wr & (req_code != REQ_SAFEOP)) refuse = 1'b1;
      end
      ST_OP: begin
        if (req_wr & (req_code == REQ_SAFEOP)) st_d = ST_SAFEOP;
        else if (req_wr & (req_code == REQ_PREOP)) st_d = ST_PREOP;
        else if (req_wr & (req_code == REQ_INIT)) st_d = ST_INIT;
        else if (req_wr & (req_code != REQ_OP)) refuse = 1'b1;
      end
      ST_BOOT: begin
        if (req_wr & (req_code == REQ_INIT)) st_d = ST_INIT;
        else if (req_wr & (req_code != REQ_BOOT)) refuse = 1'b1;
      end
      default: st_d = ST_INIT;
    endcase
  end

  // output gating: a sync trip forces zero but never moves the state
  wire         wd_off    = ~wd_active[0];
  wire         out_live  = ((st_q == ST_OP) | ((st_q == ST_SAFEOP) & wd_off)) & ~wd_trip_q[0];
  logic [OUT_W-1:0] pd_hold_q;
  wire [OUT_W-1:0]  out_d = out_live ? pd_hold_q : '0;

  always_ff @(posedge I_REF_CLK or posedge I_RESET) begin
    if (I_RESET) begin
      st_q          <= ST_INIT;
      refused_q     <= 1'b0;
      pd_hold_q     <= '0;
      O_OUTPUTS     <= '0;
      O_MBX_ALLOWED <= 1'b0;
      O_FOE_ONLY    <= 1'b0;
      O_PD_ALLOWED  <= 1'b0;
      O_INPUT_LOAD  <= 1'b0;
      O_SM_TRIP     <= 1'b0;
      O_PDI_TRIP    <= 1'b0;
    end else begin
      st_q          <= st_d;
      if (req_wr) refused_q <= refuse;
      if (wd_restart[0]) pd_hold_q <= pd_data;
      O_OUTPUTS     <= out_d;
      O_MBX_ALLOWED <= mbx_ok;
      O_FOE_ONLY    <= st_q == ST_BOOT;
      O_PD_ALLOWED  <= pd_ok;
      O_INPUT_LOAD  <= st_q == ST_LOAD;
      O_SM_TRIP     <= wd_trip_q[0];
      O_PDI_TRIP    <= wd_trip_q[1];
    end
  end

  // checks
  default clocking cb @(posedge I_REF_CLK); endclocking
  default disable iff (I_RESET);

  sequence s_load_req;
    st_q == ST_PREOP && st_d == ST_LOAD;
  endsequence
  sequence s_safeop_ack;
    st_q == ST_LOAD ##1 st_q == ST_SAFEOP && O_INPUT_LOAD;
  endsequence

  a_sm_restart_clear: assert property (wd_restart[0] |=> wd_cnt_q[0] == 16'h0 && !wd_trip_q[0])
    else $error("sync watchdog not restarted by exchange");
  a_sm_trip_outputs: assert property (wd_trip_q[0] |=> O_OUTPUTS == '0)
    else $error("outputs not forced off after sync trip");
  a_trip_keeps_state: assert property ($rose(wd_trip_q[0]) && !req_wr |=> $stable(st_q))
    else $error("sync trip changed slave state");
  a_pdi_trip_cause: assert property ($rose(wd_trip_q[1]) |-> $past(wd_cnt_q[1]) >= pdi_tmr_q && $past(wd_active[1]))
    else $error("local watchdog tripped early");
  a_tick_spacing: assert property (tick |=> !tick [*8])
    else $error("watchdog ticks too close");
  a_zero_disables: assert property (sm_tmr_q == 16'h0 |=> !wd_trip_q[0])
    else $error("sync watchdog active with zero timer");
  a_init_no_comm: assert property (st_q == ST_INIT |-> !mbx_ok && !pd_ok)
    else $error("communication allowed in init");
  a_load_before_ack: assert property (s_load_req |=> s_safeop_ack)
    else $error("inputs not loaded before safeop");
  a_safeop_outputs: assert property (st_q == ST_SAFEOP && wd_active[0] |=> O_OUTPUTS == '0)
    else $error("outputs live in safeop with watchdog on");
  a_boot_from_init: assert property ($rose(st_q == ST_BOOT) |-> $past(st_q) == ST_INIT)
    else $error("boot entered from wrong state");
  a_preop_mbx_only: assert property (st_q == ST_PREOP |-> mbx_ok && !pd_ok)
    else $error("preop permissions wrong");

endmodule

// file: verilog/wdog_state_pkg.sv
/*
  shared constants for the output watchdog and slave state control block:
  register offsets, field positions, reset values, state codes and timing.
  assumes a single 125 MHz clock and a 32-bit APB register bus.
*/
package wdog_state_pkg;

  // clock and watchdog base timing
  localparam int          CLK_PERIOD_NS  = 8;
  localparam int          BASE_PERIOD_NS = 40;                      // 25 MHz base clock
  localparam int          BASE_DIV       = BASE_PERIOD_NS / CLK_PERIOD_NS;
  localparam logic [2:0]  BASE_LAST      = 3'(BASE_DIV - 1);
  localparam logic [16:0] TICK_EXTRA     = 17'h00001;               // mult + 2 periods, counted from 0
  localparam int          DEFAULT_MON_MS = 100;                     // 1000 ticks of 100 us

  // register byte offsets
  localparam logic [11:0] OFS_CTRL    = 12'h000;
  localparam logic [11:0] OFS_REQ     = 12'h004;
  localparam logic [11:0] OFS_STATUS  = 12'h008;
  localparam logic [11:0] OFS_MULT    = 12'h00C;
  localparam logic [11:0] OFS_SM_TMR  = 12'h010;
  localparam logic [11:0] OFS_PDI_TMR = 12'h014;

  // field positions
  localparam int CTRL_SM_EN    = 0;
  localparam int CTRL_PDI_EN   = 1;
  localparam int STAT_SM_TRIP  = 8;
  localparam int STAT_PDI_TRIP = 9;
  localparam int STAT_REFUSED  = 10;

  // reset values
  localparam logic [1:0]  CTRL_RST    = 2'h3;
  localparam logic [15:0] MULT_RST    = 16'h09C2;                   // 2498
  localparam logic [15:0] SM_TMR_RST  = 16'h03E8;                   // 1000
  localparam logic [15:0] PDI_TMR_RST = 16'h03E8;                   // 1000

  // state request codes written to OFS_REQ
  localparam logic [2:0] REQ_INIT   = 3'h1;
  localparam logic [2:0] REQ_PREOP  = 3'h2;
  localparam logic [2:0] REQ_BOOT   = 3'h3;
  localparam logic [2:0] REQ_SAFEOP = 3'h4;
  localparam logic [2:0] REQ_OP     = 3'h5;

  localparam int OUT_W = 8;

  typedef enum logic [5:0] {
    ST_INIT   = 6'b000001,
    ST_PREOP  = 6'b000010,
    ST_SAFEOP = 6'b000100,
    ST_OP     = 6'b001000,
    ST_BOOT   = 6'b010000,
    ST_LOAD   = 6'b100000
  } slave_state_e;

endpackage
